// >>> rtl/pmrm_pkg.sv
/*
  Package for the phase monitor register map: addresses, widths and the
  divider and timing constants of the phase measurement chain.
  Assumes a single 20 MHz reference clock domain.
*/
`default_nettype none
package pmrm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 24;
  localparam int LOW_W = 16;
  localparam int HIGH_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_REF0_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_REF0_HIGH = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_REF90_LOW = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_REF90_HIGH = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TEST_PATH = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_DET_LEVEL = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_LOCK = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_LO = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_HI = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_DET_LEVEL2 = 8'h16;
  localparam int TEST_PATH_BIT = 0;
  localparam logic TEST_PATH_RESET = 1'b0;
  // measurement tick: the 5 MHz count rate taken from the 20 MHz clock
  localparam int CLK_HZ = 20_000_000;
  localparam int MEAS_HZ = 5_000_000;
  localparam int TICK_DIV = CLK_HZ / MEAS_HZ;
  // 5 MHz -> 2083.3 Hz -> 130.2 Hz reference chain
  localparam int PRE_DIV = 2400;
  localparam int REF_DIV = 16;
  localparam logic [3:0] REF90_PRELOAD = 4'hC;
  localparam int PPS_PER_LATCH = 3;
  localparam int SETTLE_PERIODS = 8;
endpackage
`default_nettype wire

// >>> rtl/pmrm_phase_monitor.sv
/*
  Phase monitor register map: two gated 24-bit phase counters, the
  130 Hz reference chain, the latch and clear sequence on every third
  timing pulse, and the parallel monitor/control port.
  Assumes the interface board holds address, data and direction stable
  while device_request is high; pin inputs are synchronised here.
*/
`default_nettype none
module pmrm_phase_monitor
  import pmrm_pkg::*;
#(
  parameter logic [7:0] SERIAL_NUMBER = 8'h01,
  // arbitrary neutral value
  parameter logic [7:0] MODULE_ID = 8'h5A,
  parameter int PRE_DIV_P = PRE_DIV
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  // monitor/control port
  input  wire logic                      device_request,
  input  wire logic                      writeNotRead,
  input  wire logic [pmrm_pkg::ADDR_W-1:0] address,
  input  wire logic [pmrm_pkg::DATA_W-1:0] cmdDataIn,
  input  wire logic                      identity_read_strobe,
  output logic [pmrm_pkg::DATA_W-1:0]    cmdDataOut,
  output logic                           cmdDataOe,
  output logic                           access_acknowledge,
  output logic                           analog_monitor_select,
  // measurement pins
  input  wire logic                      signalIn,
  input  wire logic                      timingPulse,
  input  wire logic                      lockDetectN,
  output logic                           path_switch_output,
  output logic                           refOut
);
  import pmrm_pkg::*;

  logic [1:0] reqS, wrS, sigS, ppsS, lockS, idS;
  logic       ppsD_reg;
  always_ff @(posedge ref_clk) begin
    reqS  <= {reqS[0], device_request};
    wrS   <= {wrS[0], writeNotRead};
    sigS  <= {sigS[0], signalIn};
    ppsS  <= {ppsS[0], timingPulse};
    lockS <= {lockS[0], lockDetectN};
    idS   <= {idS[0], identity_read_strobe};
    ppsD_reg <= ppsS[1];
  end
  wire logic ppsRise = ppsS[1] & ~ppsD_reg;

  typedef enum {PMRM_RUN, PMRM_LATCH, PMRM_CLEAR, PMRM_SETTLE} pmrm_st_t;

  function automatic logic isAnalog(input logic [ADDR_W-1:0] a);
    isAnalog = (a == ADDR_DET_LEVEL) ||
               (a >= ADDR_ANALOG_LO && a <= ADDR_ANALOG_HI);
  endfunction

  function automatic logic isDigital(input logic [ADDR_W-1:0] a);
    isDigital = (a <= ADDR_TEST_PATH) || (a == ADDR_LOCK);
  endfunction

  // measurement state
  pmrm_st_t           st_reg, st_next;
  logic [1:0]         tickCnt_reg, tickCnt_next;
  logic [11:0]        pre_reg, pre_next;
  logic [3:0]         div0_reg, div0_next, div90_reg, div90_next;
  logic [1:0]         ppsCnt_reg, ppsCnt_next;
  logic [3:0]         settle_reg, settle_next;
  logic [CNT_W-1:0]   cnt0_reg, cnt0_next, cnt90_reg, cnt90_next;
  logic [CNT_W-1:0]   lat0_reg, lat0_next, lat90_reg, lat90_next;
  logic               ref0, ref90, tick, preWrap, ref0Wrap;

  assign ref0 = div0_reg[3];
  assign ref90 = div90_reg[3];

  always_comb begin
    st_next = st_reg;
    tickCnt_next = tickCnt_reg + 2'h1;
    tick = (tickCnt_reg == 2'(TICK_DIV - 1));
    preWrap = tick && (pre_reg == 12'(PRE_DIV_P - 1));
    ref0Wrap = preWrap && (div0_reg == 4'(REF_DIV - 1));
    pre_next = pre_reg;
    div0_next = div0_reg;
    div90_next = div90_reg;
    ppsCnt_next = ppsCnt_reg;
    settle_next = settle_reg;
    cnt0_next = cnt0_reg;
    cnt90_next = cnt90_reg;
    lat0_next = lat0_reg;
    lat90_next = lat90_reg;
    if (tick) begin
      pre_next = preWrap ? 12'h000 : pre_reg + 12'h001;
    end
    if (preWrap) begin
      div0_next = div0_reg + 4'h1;
      div90_next = div90_reg + 4'h1;
    end
    if (ppsRise) begin
      ppsCnt_next = (ppsCnt_reg == 2'(PPS_PER_LATCH - 1)) ?
                    2'h0 : ppsCnt_reg + 2'h1;
    end
    case (st_reg)
      PMRM_RUN: begin
        if (tick) begin
          if (sigS[1] ^ ref0) cnt0_next = cnt0_reg + 24'h000001;
          if (sigS[1] ^ ref90) cnt90_next = cnt90_reg + 24'h000001;
        end
        if (ppsRise && ppsCnt_reg == 2'(PPS_PER_LATCH - 1)) begin
          st_next = PMRM_LATCH;
        end
      end
      PMRM_LATCH: begin
        lat0_next = cnt0_reg;
        lat90_next = cnt90_reg;
        st_next = PMRM_CLEAR;
      end
      PMRM_CLEAR: begin
        cnt0_next = '0;
        cnt90_next = '0;
        tickCnt_next = 2'h0;
        pre_next = 12'h000;
        div0_next = 4'h0;
        div90_next = REF90_PRELOAD;
        settle_next = 4'h0;
        st_next = PMRM_SETTLE;
      end
      PMRM_SETTLE: begin
        if (ref0Wrap) begin
          settle_next = settle_reg + 4'h1;
          if (settle_reg == 4'(SETTLE_PERIODS - 1)) st_next = PMRM_RUN;
        end
      end
      default: st_next = PMRM_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= PMRM_RUN;
      tickCnt_reg <= 2'h0;
      pre_reg <= 12'h000;
      div0_reg <= 4'h0;
      div90_reg <= REF90_PRELOAD;
      ppsCnt_reg <= 2'h0;
      settle_reg <= 4'h0;
      cnt0_reg <= '0;
      cnt90_reg <= '0;
      lat0_reg <= '0;
      lat90_reg <= '0;
    end else begin
      st_reg <= st_next;
      tickCnt_reg <= tickCnt_next;
      pre_reg <= pre_next;
      div0_reg <= div0_next;
      div90_reg <= div90_next;
      ppsCnt_reg <= ppsCnt_next;
      settle_reg <= settle_next;
      cnt0_reg <= cnt0_next;
      cnt90_reg <= cnt90_next;
      lat0_reg <= lat0_next;
      lat90_reg <= lat90_next;
    end
  end

  // bus port state; answers held while request stays high
  logic                test_reg, test_next;
  logic [DATA_W-1:0]   dout_reg, dout_next;
  logic                oe_reg, oe_next, ack_reg, ack_next;
  logic                an_reg, an_next, sw_reg, sw_next, ref_reg, ref_next;
  logic [ADDR_W-1:0]   addrM_reg, addrS_reg;
  logic [DATA_W-1:0]   dataM_reg, dataS_reg;

  // two stages like the request, so address and request fall together
  always_ff @(posedge ref_clk) begin
    addrM_reg <= address;
    addrS_reg <= addrM_reg;
    dataM_reg <= cmdDataIn;
    dataS_reg <= dataM_reg;
  end

  always_comb begin
    test_next = test_reg;
    dout_next = 16'h0000;
    oe_next = 1'b0;
    ack_next = 1'b0;
    an_next = 1'b0;
    sw_next = test_reg;
    ref_next = ref0;
    if (idS[1]) begin
      dout_next = {8'h00, MODULE_ID};
      oe_next = 1'b1;
    end else if (reqS[1]) begin
      an_next = isAnalog(addrS_reg);
      ack_next = isDigital(addrS_reg);
      if (wrS[1]) begin
        ack_next = (addrS_reg == ADDR_TEST_PATH);
        if (addrS_reg == ADDR_TEST_PATH && !ack_reg) begin
          test_next = dataS_reg[TEST_PATH_BIT];
        end
      end else begin
        oe_next = ack_next;
        case (addrS_reg)
          ADDR_REF0_LOW:   dout_next = lat0_reg[LOW_W-1:0];
          ADDR_REF0_HIGH:  dout_next = {8'h00, lat0_reg[CNT_W-1:LOW_W]};
          ADDR_REF90_LOW:  dout_next = lat90_reg[LOW_W-1:0];
          ADDR_REF90_HIGH: dout_next = {8'h00, lat90_reg[CNT_W-1:LOW_W]};
          ADDR_SERIAL:     dout_next = {8'h00, SERIAL_NUMBER};
          ADDR_TEST_PATH:  dout_next = {15'h0000, test_reg};
          ADDR_LOCK:       dout_next = {15'h0000, lockS[1]};
          default:         dout_next = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      test_reg <= TEST_PATH_RESET;
      dout_reg <= 16'h0000;
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      an_reg <= 1'b0;
      sw_reg <= TEST_PATH_RESET;
      ref_reg <= 1'b0;
    end else begin
      test_reg <= test_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      an_reg <= an_next;
      sw_reg <= sw_next;
      ref_reg <= ref_next;
    end
  end

  assign cmdDataOut = dout_reg;
  assign cmdDataOe = oe_reg;
  assign access_acknowledge = ack_reg;
  assign analog_monitor_select = an_reg;
  assign path_switch_output = sw_reg;
  assign refOut = ref_reg;

  no_ack_unmapped_a: assert property (@(posedge ref_clk) disable iff (srst)
    (reqS[1] && !isDigital(addrS_reg) && !idS[1]) |=> !access_acknowledge)
    else $error("ack on unmapped address");
  switch_follows_a: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 path_switch_output == $past(test_reg))
    else $error("switch output not following setting");
  preload_ninety_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg == PMRM_CLEAR |=> div90_reg == 4'hC && div0_reg == 4'h0)
    else $error("90 degree divider not preloaded");
  latch_stable_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg != PMRM_LATCH |=> $stable(lat0_reg) && $stable(lat90_reg))
    else $error("latched count changed outside latch");
  latch_clear_seq_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg == PMRM_LATCH |=> st_reg == PMRM_CLEAR ##1 cnt0_reg == 24'h0)
    else $error("latch not followed by clear");
  halt_count_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg == PMRM_SETTLE |=> $stable(cnt0_reg) && $stable(cnt90_reg))
    else $error("counting during settle");
  write_only_five_a: assert property (@(posedge ref_clk) disable iff (srst)
    (reqS[1] && wrS[1] && addrS_reg != ADDR_TEST_PATH) |=> $stable(test_reg))
    else $error("write took effect at wrong address");
  lock_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (reqS[1] && !wrS[1] && !idS[1] && addrS_reg == ADDR_LOCK)
    |=> cmdDataOut[0] == $past(lockS[1]) && access_acknowledge)
    else $error("lock readback wrong");
endmodule
`default_nettype wire

// >>> test/pmrm_board_model.sv
/*
  Behavioural monitor/control interface board driving the phase monitor.
  Assumes the bench calls access() and samples resValid on ref_clk.
*/
`default_nettype none
module pmrm_board_model (
  // clock
  input  wire logic                          ref_clk,
  // port towards the device
  output logic                               device_request,
  output logic                               writeNotRead,
  output logic [pmrm_pkg::ADDR_W-1:0]        address,
  output logic [pmrm_pkg::DATA_W-1:0]        cmdDataIn,
  input  wire logic                          access_acknowledge,
  input  wire logic                          analog_monitor_select,
  input  wire logic [pmrm_pkg::DATA_W-1:0]   cmdDataOut,
  // result towards the bench
  output logic                               resValid,
  output logic [pmrm_pkg::DATA_W+1:0]        resWord
);
  timeunit 1ns;
  timeprecision 1ns;
  import pmrm_pkg::*;
  initial begin
    device_request = 1'b0;
    writeNotRead = 1'b0;
    address = 8'h00;
    cmdDataIn = 16'h0000;
    resValid = 1'b0;
    resWord = '0;
  end
  // one access per request, request dropped before the next
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [15:0] d);
    logic gotAck;
    logic gotAna;
    gotAck = 1'b0;
    gotAna = 1'b0;
    @(negedge ref_clk);
    device_request <= 1'b1;
    writeNotRead <= wr;
    address <= a;
    cmdDataIn <= d;
    for (int i = 0; i < 8 && !(gotAck || gotAna); i++) begin
      @(negedge ref_clk);
      gotAck = (access_acknowledge === 1'b1);
      gotAna = (analog_monitor_select === 1'b1);
    end
    resWord <= {gotAck, gotAna, (gotAck && !wr) ? cmdDataOut : 16'h0000};
    resValid <= 1'b1;
    device_request <= 1'b0;
    // released lines go to the inverse so stale values cannot pass
    address <= ~a;
    cmdDataIn <= ~d;
    writeNotRead <= ~wr;
    @(negedge ref_clk);
    resValid <= 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
/*
  Self-checking bench for the phase monitor register map.
  Assumes the board model as far side; results checked from a queue.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmrm_pkg::*;
  localparam logic [7:0] SERIAL = 8'h2B;
  // arbitrary identity value
  localparam logic [7:0] ID_VAL = 8'hA6;
  // input held low: 0 deg ref high for two half periods of 24 ticks;
  // 90 deg starts at 12, adding a 12-tick head before its first low
  localparam logic [15:0] CNT0_EXP = 16'h0030;
  localparam logic [15:0] CNT90_EXP = 16'h003C;
  logic        ref_clk, srst, identity_read_strobe;
  logic        signalIn, timingPulse, lockDetectN;
  logic        rndOn, pulseReq;
  logic        device_request, writeNotRead, resValid;
  logic        cmdDataOe, access_acknowledge, analog_monitor_select;
  logic        path_switch_output, refOut;
  logic [7:0]  address;
  logic [15:0] cmdDataIn, cmdDataOut;
  logic [17:0] resWord;
  logic [35:0] expQ[$];
  logic [35:0] ent;
  logic [31:0] lfsrState;
  int          miscompares, n_checks;
  pmrm_phase_monitor #(.SERIAL_NUMBER(SERIAL), .MODULE_ID(ID_VAL),
    .PRE_DIV_P(3)) dut_u (.ref_clk(ref_clk), .srst(srst),
    .device_request(device_request), .writeNotRead(writeNotRead),
    .address(address), .cmdDataIn(cmdDataIn),
    .identity_read_strobe(identity_read_strobe),
    .cmdDataOut(cmdDataOut), .cmdDataOe(cmdDataOe),
    .access_acknowledge(access_acknowledge),
    .analog_monitor_select(analog_monitor_select),
    .signalIn(signalIn), .timingPulse(timingPulse),
    .lockDetectN(lockDetectN), .path_switch_output(path_switch_output),
    .refOut(refOut));
  pmrm_board_model board_u (.ref_clk(ref_clk),
    .device_request(device_request), .writeNotRead(writeNotRead),
    .address(address), .cmdDataIn(cmdDataIn),
    .access_acknowledge(access_acknowledge),
    .analog_monitor_select(analog_monitor_select),
    .cmdDataOut(cmdDataOut), .resValid(resValid), .resWord(resWord));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [17:0] e, input logic [17:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // note the expectation, then let the board make the access
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [15:0] d, input logic [17:0] m,
                     input logic [17:0] e);
    expQ.push_back({m, e});
    board_u.access(wr, a, d);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // random measurement pins toggle while the monitor settles; counters and latches hold
  always @(negedge ref_clk) begin
    lfsrState = lfsr(lfsrState);
    signalIn = rndOn & lfsrState[0];
    timingPulse = rndOn ? (lfsrState[4] & lfsrState[9] & lfsrState[13])
                        : pulseReq;
  end
  always @(posedge ref_clk) begin
    if (resValid === 1'b1) begin
      ent = (expQ.size() > 0) ? expQ.pop_front() : {18'h3FFFF, ~resWord};
      chk(ent[17:0] & ent[35:18], resWord & ent[35:18]);
    end
  end
  initial begin
    #(4000 * 50);
    miscompares++;
    report_and_stop();
  end
  initial begin
    lfsrState = 32'hB35D;
    srst = 1'b1;
    identity_read_strobe = 1'b0;
    lockDetectN = 1'b0;
    rndOn = 1'b0;
    pulseReq = 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) srst = 1'b0;
    // third pulse placed so the latch falls while both references are low
    for (int p = 0; p < 3; p++) begin
      repeat (p == 2 ? 251 : 100) @(negedge ref_clk);
      chk({17'h0, p == 0}, {17'h0, refOut});
      pulseReq <= 1'b1;
      @(negedge ref_clk) pulseReq <= 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    rndOn = 1'b1;
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 8'h05, lfsrState[15:0] & 16'hFFFE | 16'(i),
          18'h30000, 18'h20000);
      acc(1'b0, 8'h05, 16'h0000, 18'h3FFFF, 18'h20000 | 18'(i));
      chk({17'h0, 1'(i)}, {17'h0, path_switch_output});
    end
    // refused write must leave the switch as it was
    acc(1'b1, 8'h04, 16'h0000, 18'h3FFFF, 18'h00000);
    acc(1'b0, 8'h05, 16'h0000, 18'h3FFFF, 18'h20001);
    acc(1'b0, 8'h04, 16'h0000, 18'h3FFFF, {10'h200, SERIAL});
    for (int i = 0; i < 4; i++)
      acc(1'b0, 8'(i), 16'h0000, 18'h3FFFF,
          {2'b10, (i == 0) ? CNT0_EXP : (i == 2) ? CNT90_EXP : 16'h0000});
    for (int j = 0; j < 2; j++) begin
      lockDetectN = 1'(j);
      acc(1'b0, 8'h08, 16'h0000, 18'h3FFFF, 18'h20000 | 18'(j));
    end
    acc(1'b0, 8'h06, 16'h0000, 18'h3FFFF, 18'h10000);
    acc(1'b0, 8'h10, 16'h0000, 18'h3FFFF, 18'h10000);
    acc(1'b0, 8'h16, 16'h0000, 18'h3FFFF, 18'h10000);
    acc(1'b0, 8'h17, 16'h0000, 18'h3FFFF, 18'h10000);
    acc(1'b0, 8'h07, 16'h0000, 18'h3FFFF, 18'h00000);
    acc(1'b0, 8'h09, 16'h0000, 18'h3FFFF, 18'h00000);
    acc(1'b0, 8'hFF, 16'h0000, 18'h3FFFF, 18'h00000);
    @(negedge ref_clk) identity_read_strobe = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({1'b1, 9'h000, ID_VAL}, {cmdDataOe, 9'h000, cmdDataOut[7:0]});
    identity_read_strobe = 1'b0;
    repeat (4) @(negedge ref_clk);
    if (expQ.size() != 0)
      miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
